// file: core/pfr_cycle_timer.v
/*
 * counts a fixed number of instruction cycles after a start pulse and
 * flags done, without a register, in the last enabled cycle, so the
 * owner can end the access on that same edge; a start while busy is ignored.
 * assumes the start pulse and the cycle enable are on i_ref_clk.
 */
`default_nettype none

module pfr_cycle_timer #(
    parameter CYCLES = 2
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_cyc_en,
    input wire i_start,
    output reg o_busy,
    output reg o_done
);

reg [3:0] cnt_r;

// last enabled cycle of the access
always @* begin
    o_done = o_busy && i_cyc_en && (cnt_r == CYCLES[3:0] - 4'h1);
end

always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        cnt_r <= 4'h0;
        o_busy <= 1'b0;
    end else begin
        if (!o_busy) begin
            if (i_start) begin
                o_busy <= 1'b1;
                cnt_r <= 4'h0;
            end
        end else if (i_cyc_en) begin
            if (o_done) begin
                o_busy <= 1'b0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
end

endmodule

`default_nettype wire

// file: core/pfr_defs.vh
/*
 * constants for the program flash read port: register offsets, field
 * positions and widths, and access timing.
 * assumes inclusion by bare name from the design files under core/.
 */
// Operation
// - software can read back one whole flash word of up to fourteen bits while running.
// - the high and low data registers together give the fourteen-bit word, low byte below.
// - the high and low address registers together form the thirteen-bit word address.
// - unused upper bits of the high data and high address registers read as zero.
// - the address registers can select any word of a flash of up to 8K words.
// - writing one to the read-start bit launches a read and writing zero does nothing.
// - hardware clears the read-start bit when the read ends, so zero means done.
// - bit seven of the control register reads as one and bits six to one read as zero.
// - after the start bit is set the next two instruction cycles perform the access.
// - software waits two no-operations and the word is then in the data registers.
// - the data registers keep the fetched word until another read replaces it.
// - internal reads are allowed whatever the code protection setting.
`ifndef PFR_DEFS_VH
`define PFR_DEFS_VH

`define PFR_ADDR_W 9
`define PFR_OFS_DATA_LOW 9'h10c
`define PFR_OFS_ADDR_LOW 9'h10d
`define PFR_OFS_DATA_HIGH 9'h10e
`define PFR_OFS_ADDR_HIGH 9'h10f
`define PFR_OFS_CONTROL 9'h18c

`define PFR_FLASH_AW 13
`define PFR_FLASH_DW 14
`define PFR_HIGH_ADDR_BITS 5
`define PFR_HIGH_DATA_BITS 6
`define PFR_CTRL_START_BIT 0
`define PFR_CTRL_RSVD_BIT 7
`define PFR_ACCESS_CYCLES 2

`endif

// file: core/pfr_read_port.v
/*
 * program flash read port: address, data and control registers reached
 * over a plain strobe port, and a read engine that fetches one word.
 * assumes a synchronous flash array that returns data the cycle after
 * its read strobe, and an instruction-cycle enable from the core.
 */
// Implementation choice: strobed register access.
`include "pfr_defs.vh"
`default_nettype none

module pfr_read_port #(
    parameter ACCESS_CYCLES = `PFR_ACCESS_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_cyc_en,
    input wire [`PFR_ADDR_W-1:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    output reg o_flash_rd,
    output reg [`PFR_FLASH_AW-1:0] o_flash_addr,
    input wire [`PFR_FLASH_DW-1:0] i_flash_data,
    output reg o_read_busy
);

// =====================================================
// registers
reg [7:0] addr_low_r;
reg [`PFR_HIGH_ADDR_BITS-1:0] addr_high_r;
reg [7:0] data_low_r;
reg [`PFR_HIGH_DATA_BITS-1:0] data_high_r;
reg start_r;
reg capture_r;

wire ctrl_wr = i_reg_wr && (i_reg_addr == `PFR_OFS_CONTROL);
wire launch = ctrl_wr && i_reg_wdata[`PFR_CTRL_START_BIT] && !start_r;
wire timer_busy;
wire timer_done;

// =====================================================
// access timing
pfr_cycle_timer #(
    .CYCLES(ACCESS_CYCLES)
) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_cyc_en(i_cyc_en),
    .i_start(launch),
    .o_busy(timer_busy),
    .o_done(timer_done)
);

// =====================================================
// address registers and control
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        addr_low_r <= 8'h00;
        addr_high_r <= {`PFR_HIGH_ADDR_BITS{1'b0}};
        start_r <= 1'b0;
        o_flash_rd <= 1'b0;
        o_flash_addr <= {`PFR_FLASH_AW{1'b0}};
        o_read_busy <= 1'b0;
        capture_r <= 1'b0;
    end else begin
        if (i_reg_wr && i_reg_addr == `PFR_OFS_ADDR_LOW) begin
            addr_low_r <= i_reg_wdata;
        end
        if (i_reg_wr && i_reg_addr == `PFR_OFS_ADDR_HIGH) begin
            addr_high_r <= i_reg_wdata[`PFR_HIGH_ADDR_BITS-1:0];
        end
        // flash asked at launch, word captured next cycle; no protect gate
        o_flash_rd <= launch;
        capture_r <= o_flash_rd;
        if (launch) begin
            o_flash_addr <= {addr_high_r, addr_low_r};
        end
        if (launch) begin
            start_r <= 1'b1;
        end else if (timer_done) begin
            start_r <= 1'b0;
        end
        o_read_busy <= launch || (start_r && !timer_done);
    end
end

// =====================================================
// data holding registers
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        data_low_r <= 8'h00;
        data_high_r <= {`PFR_HIGH_DATA_BITS{1'b0}};
    end else if (capture_r) begin
        data_low_r <= i_flash_data[7:0];
        data_high_r <= i_flash_data[`PFR_FLASH_DW-1:8];
    end
end

// =====================================================
// read mux
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
        case (i_reg_addr)
            `PFR_OFS_DATA_LOW: o_reg_rdata <= data_low_r;
            `PFR_OFS_DATA_HIGH: o_reg_rdata <= {2'b00, data_high_r};
            `PFR_OFS_ADDR_LOW: o_reg_rdata <= addr_low_r;
            `PFR_OFS_ADDR_HIGH: o_reg_rdata <= {3'b000, addr_high_r};
            `PFR_OFS_CONTROL: o_reg_rdata <= {1'b1, 6'h00, start_r};
            default: o_reg_rdata <= 8'h00;
        endcase
    end else begin
        o_reg_rdata <= 8'h00;
    end
end

endmodule

`default_nettype wire

// file: testbench/pfr_flash_model.sv
/* flash array model: a word derived from the address, one clock after
   the strobe; assumes the read port samples it in the following cycle */
`default_nettype none
module pfr_flash_model (
    input wire logic i_ref_clk,
    input wire logic i_rd,
    input wire logic [12:0] i_addr,
    output logic [13:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // word valid one cycle, then the lines keep changing
    always @(posedge i_ref_clk) begin
        o_data <= i_rd ? {i_addr[0], i_addr} ^ 14'h2a5a : ~o_data;
    end
endmodule
`default_nettype wire

// file: testbench/pfr_read_port_sva.sv
/* port assertions for pfr_read_port
   assumes i_cyc_en held high */
`default_nettype none
module pfr_read_port_sva (
    input wire logic i_ref_clk, i_rst_b, i_cyc_en, i_reg_wr, i_reg_rd,
    input wire logic [8:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata, o_reg_rdata,
    input wire logic o_flash_rd, o_read_busy,
    input wire logic [12:0] o_flash_addr,
    input wire logic [13:0] i_flash_data
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire go = i_reg_wr && i_reg_addr == 9'h18c && !o_read_busy;
    sequence s_access;
        o_read_busy[*2] ##1 !o_read_busy;
    endsequence
    AST_LAUNCH: assert property (go && i_reg_wdata[0] |=> o_flash_rd && o_read_busy)
        else $error("no launch");
    AST_ZERO: assert property (go && !i_reg_wdata[0] |=> !o_flash_rd)
        else $error("zero launched");
    AST_ACCESS: assert property ($rose(o_read_busy) |-> s_access)
        else $error("access length");
    AST_START: assert property (o_flash_rd |-> $rose(o_read_busy))
        else $error("stray strobe");
    AST_RETRIG: assert property (o_read_busy && $past(o_read_busy) |-> !o_flash_rd)
        else $error("second access");
    AST_CTRL: assert property (i_reg_rd && i_reg_addr == 9'h18c
        |=> o_reg_rdata == {7'h40, $past(o_read_busy)}) else $error("control");
    AST_ADDR_HI: assert property (i_reg_rd && i_reg_addr == 9'h10f
        |=> o_reg_rdata[7:5] == 3'h0) else $error("address high");
    AST_DATA_HI: assert property (i_reg_rd && i_reg_addr == 9'h10e
        |=> o_reg_rdata[7:6] == 2'h0) else $error("data high");
endmodule
bind pfr_read_port pfr_read_port_sva i_pfr_read_port_sva (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cyc_en(i_cyc_en), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_flash_rd(o_flash_rd), .o_read_busy(o_read_busy), .o_flash_addr(o_flash_addr),
    .i_flash_data(i_flash_data));
`default_nettype wire

// file: testbench/testbench.sv
/* self-checking bench for pfr_read_port beside a flash model
   assumes the core files and the checker compile alongside */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_rst_b = 0, i_reg_wr = 0, i_reg_rd = 0, pend = 0;
    logic [8:0] i_reg_addr = 0;
    logic [7:0] i_reg_wdata = 0, o_reg_rdata;
    logic o_flash_rd, o_read_busy;
    logic [12:0] o_flash_addr, a;
    logic [13:0] i_flash_data, w;
    logic [7:0] exp_q[$];
    int error_cnt = 0, checks_done = 0;
    always #2 i_ref_clk = ~i_ref_clk;
    pfr_read_port i_pfr_read_port (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cyc_en(1'b1),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_flash_rd(o_flash_rd),
        .o_flash_addr(o_flash_addr), .i_flash_data(i_flash_data), .o_read_busy(o_read_busy));
    pfr_flash_model i_pfr_flash_model (.i_ref_clk(i_ref_clk), .i_rd(o_flash_rd),
        .i_addr(o_flash_addr), .o_data(i_flash_data));
    task chk(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value reg_rdata expected %h seen %h", want, seen);
        end
    endtask
    // one write or one read; a read notes its expected answer
    task bus(input logic wr, input logic [8:0] ad, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= wr;
        i_reg_rd <= !wr;
        i_reg_addr <= ad;
        i_reg_wdata <= d;
        if (!wr) exp_q.push_back(d);
        @(posedge i_ref_clk);
        i_reg_wr <= 0;
        i_reg_rd <= 0;
    endtask
    always @(posedge i_ref_clk) begin
        if (pend) chk(o_reg_rdata, exp_q.pop_front());
        pend <= i_reg_rd;
    end
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        conclude;
    end
    initial begin
        void'($urandom(32'hc862_d5cb));
        repeat (10) @(posedge i_ref_clk);
        i_rst_b <= 1;
        bus(0, 9'h18c, 8'h80);
        bus(0, 9'h10e, 8'h00);
        bus(0, 9'h100, 8'h00);
        $display("test reset done");
        repeat (6) begin
            a = 13'($urandom);
            w = {a[0], a} ^ 14'h2a5a;
            bus(1, 9'h10f, {3'h0, a[12:8]});
            bus(1, 9'h10d, a[7:0]);
            bus(1, 9'h18c, 8'h01);
            bus(1, 9'h18c, 8'h01);
            bus(0, 9'h10c, w[7:0]);
            bus(0, 9'h10e, {2'h0, w[13:8]});
            bus(0, 9'h10f, {3'h0, a[12:8]});
            bus(0, 9'h18c, 8'h80);
            bus(1, 9'h18c, 8'h00);
            bus(0, 9'h10c, w[7:0]);
        end
        $display("test reads done");
        conclude;
    end
endmodule
`default_nettype wire
